/* File: inc/spc_defines.svh */
// constants of the serial port control registers
// What this block does
// - two mode bits pick shift, 8-bit, 9-bit modes
// - bad stop bit sets framing flag; software clears
// - control bit 7 is mode or flag per select
// - 9-bit multiprocessor: ninth bit 1 and address match
// - 8-bit multiprocessor: valid stop and address match
// - reception starts only while receive enable set
// - 9-bit modes send transmit ninth bit
// - 9-bit modes store received ninth bit
// - transmit done flag set at stop bit start (after bit 8 in shift mode); software clears
// - receive done flag set at stop sample (after bit 8 in shift mode)
// - doubling bit doubles rate of modes 1-3
// - data buffer address is two separate registers
// - shift mode clock /24 or /4 by speed-up
// - baud timer clocked /12 or /1 by speed-up
// - broadcast address is value OR mask
// - all don't-care broadcast disables address filtering
// - receive pin wake enable lets RXD activity wake
// - mode 1 rate is 2^double/32 times timer overflow
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH
// ****************************************
// register addresses
// ****************************************
`define SPC_ADDR_PWR 8'h87
`define SPC_ADDR_AUX 8'h8e
`define SPC_ADDR_WAKE 8'h8f
`define SPC_ADDR_CTRL 8'h98
`define SPC_ADDR_DATA 8'h99
`define SPC_ADDR_MASK 8'hb9
`define SPC_ADDR_SADR 8'ha9
// ****************************************
// reset values
// ****************************************
`define SPC_RST_PWR 8'h30
`define SPC_RST_ZERO 8'h00
// ****************************************
// field positions
// ****************************************
`define SPC_PWR_DBL 7
`define SPC_PWR_FSEL 6
`define SPC_AUX_T1X 6
`define SPC_AUX_M0X 5
`define SPC_WAKE_RXD 6
// ****************************************
// divider counts
// ****************************************
`define SPC_DIV12 8'd12
`define SPC_DIV2 8'd2
`define SPC_OVS 4'd15
`endif

/* File: inc/spc_pkg.sv */
// types of the serial port control block
package spc_pkg;
    typedef enum logic [1:0] {
        SPC_M_SHIFT = 2'b00,
        SPC_M_UART8 = 2'b01,
        SPC_M_FIX9 = 2'b10,
        SPC_M_VAR9 = 2'b11
    } spc_mode_t;
    typedef enum logic [1:0] {
        SPC_S_IDLE = 2'b00,
        SPC_S_BUSY = 2'b01
    } spc_st_t;
    typedef struct packed {
        logic [7:0] pwr;
        logic [7:0] aux;
        logic [7:0] wake;
        logic [7:0] ctrl;
        logic [7:0] rxbuf;
        logic [7:0] mask;
        logic [7:0] sadr;
        logic [7:0] rdata;
        logic fe;
        logic [7:0] pre;
        logic [3:0] tick16;
        logic [7:0] tcnt;
        spc_st_t tst;
        logic [10:0] tsh;
        logic [3:0] tbits;
        logic [3:0] tsub;
        logic txd;
        logic sclk;
        spc_st_t rst;
        logic [9:0] rsh;
        logic [3:0] rbits;
        logic [3:0] rsub;
        logic [2:0] vote;
        logic rxd_d;
        logic wake_o;
        logic irq;
        logic oe;
    } spc_state_t;
endpackage

/* File: design/spc_serial_port.sv */
// serial port control registers with transmit and receive engines
`timescale 1ns/1ps
`default_nettype none
`include "spc_defines.svh"
module spc_serial_port
    import spc_pkg::*;
#(
    parameter logic [7:0] P_RELOAD_DEFAULT = 8'hfd
) (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // special function register port
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    // baud timer reload value and power-down state
    input wire logic [7:0] i_timer_reload,
    input wire logic i_power_down,
    input wire logic i_serial_irq_en,
    // serial pins
    input wire logic i_rxd,
    output logic o_txd,
    output logic o_rxd_out,
    output logic o_rxd_oe,
    // events
    output logic o_serial_irq,
    output logic o_wakeup
);
    spc_state_t q, d;

    // address match: mask 1 bits compare, zero broadcast disables filtering
    function automatic logic addr_ok(input logic [7:0] b, input logic [7:0] a,
                                     input logic [7:0] m);
        logic [7:0] bc;
        bc = a | m;
        if (bc == 8'h00) return 1'b1;
        return (((b ^ a) & m) == 8'h00) || (((b ^ 8'hff) & bc) == 8'h00);
    endfunction

    spc_mode_t mode;
    logic [7:0] ctrl_rd;
    logic dbl, fsel;
    assign mode = spc_mode_t'(q.ctrl[7:6]);
    assign dbl = q.pwr[`SPC_PWR_DBL];
    assign fsel = q.pwr[`SPC_PWR_FSEL];
    // bit 7 aliases the mode bit or the framing flag
    assign ctrl_rd = {fsel ? q.fe : q.ctrl[7], q.ctrl[6:0]};

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic btick, tick, stick, setti, setri, majority, nbit, st_ok, rx_accept;
        logic [7:0] rbyte;
        d = q;
        btick = 1'b0;
        tick = 1'b0;
        stick = 1'b0;
        setti = 1'b0;
        setri = 1'b0;
        majority = 1'b0;
        nbit = 1'b0;
        st_ok = 1'b0;
        rx_accept = 1'b0;
        rbyte = 8'h00;
        d.rdata = 8'h00;
        // prescaler gives timer clock, shift clock or fixed-rate ticks
        if (mode == SPC_M_SHIFT) begin
            if (q.pre >= (q.aux[`SPC_AUX_M0X] ? `SPC_DIV2 : `SPC_DIV12) - 8'd1) begin
                d.pre = 8'h00;
                stick = 1'b1;
            end else begin
                d.pre = q.pre + 8'd1;
            end
        end else if (mode == SPC_M_FIX9) begin
            // 16 ticks per bit: /64 -> every 4 clocks, /32 -> every 2
            if (q.pre >= (dbl ? 8'd1 : 8'd3)) begin
                d.pre = 8'h00;
                tick = 1'b1;
            end else begin
                d.pre = q.pre + 8'd1;
            end
        end else begin
            if (q.aux[`SPC_AUX_T1X] || q.pre >= `SPC_DIV12 - 8'd1) begin
                d.pre = 8'h00;
                btick = 1'b1;
            end else begin
                d.pre = q.pre + 8'd1;
            end
            // reload timer overflow; without doubling every second overflow counts
            if (btick) begin
                if (q.tcnt == 8'hff) begin
                    d.tcnt = i_timer_reload;
                    d.tick16[3] = ~q.tick16[3];
                    tick = dbl | q.tick16[3];
                end else begin
                    d.tcnt = q.tcnt + 8'd1;
                end
            end
        end
        // register writes
        if (i_sfr_wr) begin
            case (i_sfr_addr)
                `SPC_ADDR_PWR: d.pwr = i_sfr_wdata;
                `SPC_ADDR_AUX: d.aux = i_sfr_wdata;
                `SPC_ADDR_WAKE: d.wake = i_sfr_wdata;
                `SPC_ADDR_MASK: d.mask = i_sfr_wdata;
                `SPC_ADDR_SADR: d.sadr = i_sfr_wdata;
                `SPC_ADDR_CTRL: begin
                    if (fsel) begin
                        d.fe = i_sfr_wdata[7];
                        d.ctrl[6:0] = i_sfr_wdata[6:0];
                    end else begin
                        d.ctrl = i_sfr_wdata;
                    end
                end
                `SPC_ADDR_DATA: begin
                    // write loads transmit register and starts a frame
                    d.tst = SPC_S_BUSY;
                    d.tsub = 4'h0;
                    d.tbits = 4'h0;
                    if (mode == SPC_M_SHIFT) begin
                        d.tsh = {3'b000, i_sfr_wdata};
                    end else begin
                        d.tsh = {1'b1, q.ctrl[3], i_sfr_wdata, 1'b0};
                    end
                end
                default: d.rdata = 8'h00;
            endcase
        end
        // ---------- transmitter ----------
        if (q.tst == SPC_S_BUSY) begin
            if (mode == SPC_M_SHIFT) begin
                if (stick) begin
                    d.sclk = ~q.sclk;
                    if (q.sclk) begin
                        d.tsh = {1'b0, q.tsh[10:1]};
                        d.tbits = q.tbits + 4'd1;
                        if (q.tbits == 4'd7) setti = 1'b1;
                    end
                end
            end else if (tick) begin
                d.tsub = q.tsub + 4'd1;
                if (q.tsub == `SPC_OVS) begin
                    d.tsh = {1'b1, q.tsh[10:1]};
                    d.tbits = q.tbits + 4'd1;
                    // done at the stop bit start: after bit 9 or 10
                    if (q.tbits == ((mode == SPC_M_UART8) ? 4'd8 : 4'd9)) setti = 1'b1;
                end
            end
        end
        d.txd = (q.tst == SPC_S_BUSY) ?
                ((mode == SPC_M_SHIFT) ? q.sclk : q.tsh[0]) : 1'b1;
        // ---------- receiver ----------
        d.rxd_d = i_rxd;
        if (q.rst == SPC_S_IDLE) begin
            d.rsub = 4'h0;
            d.rbits = 4'h0;
            // reception only while enable set and no byte pending
            if (q.ctrl[4] && !q.ctrl[0]) begin
                if (mode == SPC_M_SHIFT || (q.rxd_d && !i_rxd)) d.rst = SPC_S_BUSY;
            end
        end else if (mode == SPC_M_SHIFT) begin
            if (stick) begin
                d.sclk = ~q.sclk;
                if (!q.sclk) begin
                    d.rsh = {i_rxd, q.rsh[9:1]};
                    d.rbits = q.rbits + 4'd1;
                    if (q.rbits == 4'd7) begin
                        d.rxbuf = {i_rxd, q.rsh[9:3]};
                        setri = 1'b1;
                        d.rst = SPC_S_IDLE;
                    end
                end
            end
        end else if (tick) begin
            d.rsub = q.rsub + 4'd1;
            if (q.rsub >= 4'd7 && q.rsub <= 4'd9) d.vote = {q.vote[1:0], i_rxd};
            if (q.rsub == 4'd10) begin
                majority = (q.vote[0] & q.vote[1]) | (q.vote[1] & q.vote[2]) |
                           (q.vote[0] & q.vote[2]);
                d.rsh = {majority, q.rsh[9:1]};
                d.rbits = q.rbits + 4'd1;
                if (q.rbits == 4'd0 && majority) d.rst = SPC_S_IDLE; // false start
                if (q.rbits == ((mode == SPC_M_UART8) ? 4'd9 : 4'd10)) begin
                    d.rst = SPC_S_IDLE;
                    st_ok = majority;
                    if (mode == SPC_M_UART8) begin
                        rbyte = q.rsh[9:2];
                        nbit = majority;
                    end else begin
                        rbyte = q.rsh[8:1];
                        nbit = q.rsh[9];
                    end
                    if (!st_ok) d.fe = 1'b1;
                    if (!q.ctrl[5]) begin
                        rx_accept = 1'b1;
                    end else if (mode == SPC_M_UART8) begin
                        rx_accept = st_ok && addr_ok(rbyte, q.sadr, q.mask);
                    end else begin
                        rx_accept = nbit && addr_ok(rbyte, q.sadr, q.mask);
                    end
                    if (rx_accept && !q.ctrl[0]) begin
                        d.rxbuf = rbyte;
                        d.ctrl[2] = nbit;
                        setri = 1'b1;
                    end
                end
            end
        end
        if (q.tst == SPC_S_BUSY && setti) d.tst = SPC_S_IDLE;
        // hardware set wins over a software clear in the same cycle
        if (setti) d.ctrl[1] = 1'b1;
        if (setri) d.ctrl[0] = 1'b1;
        // registered copies so the pins come straight from flip-flops
        d.irq = d.ctrl[1] | d.ctrl[0];
        d.oe = (spc_mode_t'(d.ctrl[7:6]) == SPC_M_SHIFT) && (d.tst == SPC_S_BUSY);
        // read path
        if (i_sfr_rd) begin
            case (i_sfr_addr)
                `SPC_ADDR_PWR: d.rdata = q.pwr;
                `SPC_ADDR_AUX: d.rdata = q.aux;
                `SPC_ADDR_WAKE: d.rdata = q.wake;
                `SPC_ADDR_CTRL: d.rdata = ctrl_rd;
                `SPC_ADDR_DATA: d.rdata = q.rxbuf;
                `SPC_ADDR_MASK: d.rdata = q.mask;
                `SPC_ADDR_SADR: d.rdata = q.sadr;
                default: d.rdata = 8'h00;
            endcase
        end
        // wake on falling rxd while powered down
        d.wake_o = i_power_down && q.wake[`SPC_WAKE_RXD] && i_serial_irq_en &&
                   q.rxd_d && !i_rxd;
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            q <= '0;
            q.pwr <= `SPC_RST_PWR;
            q.tcnt <= P_RELOAD_DEFAULT;
            q.txd <= 1'b1;
            q.rxd_d <= 1'b1;
            q.rsh <= 10'h3ff;
        end else if (i_ce) begin
            q <= d;
        end
    end

    // outputs straight from flip-flops
    assign o_sfr_rdata = q.rdata;
    assign o_txd = q.txd;
    assign o_rxd_out = q.tsh[0];
    assign o_rxd_oe = q.oe;
    assign o_serial_irq = q.irq;
    assign o_wakeup = q.wake_o;
endmodule
`default_nettype wire

/* File: sim/spc_chk.sv */
// port checker of the serial port control registers
`timescale 1ns/1ps
`default_nettype none
module spc_chk (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // register port
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic [7:0] o_sfr_rdata,
    // pins and events
    input wire logic i_power_down,
    input wire logic o_txd,
    input wire logic o_serial_irq,
    input wire logic o_wakeup
);
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // a mask write followed two cycles later by a mask read
    sequence mask_wr_s;
        i_ce && i_sfr_wr && i_sfr_addr == 8'hb9;
    endsequence
    sequence mask_rd_s;
        i_ce && i_sfr_rd && i_sfr_addr == 8'hb9;
    endsequence
    mask_readback_a: assert property (mask_wr_s ##2 mask_rd_s |=>
        o_sfr_rdata == $past(i_sfr_wdata, 3)) else $error("mask readback wrong");
    rdata_idle_a: assert property (i_ce && !i_sfr_rd |=> o_sfr_rdata == 8'h00)
        else $error("read data not zero when idle");
    unmapped_zero_a: assert property (i_ce && i_sfr_rd && i_sfr_addr == 8'h00
        |=> o_sfr_rdata == 8'h00) else $error("unmapped read not zero");
    // a frozen block must hold the read data and txd outputs
    freeze_hold_a: assert property (!i_ce |=> $stable(o_sfr_rdata) && $stable(o_txd))
        else $error("outputs moved while frozen");
    // flags leave only through a control write
    irq_hold_a: assert property (o_serial_irq && i_ce &&
        !(i_sfr_wr && i_sfr_addr == 8'h98) |=> o_serial_irq) else $error("flag lost");
    wake_cause_a: assert property (o_wakeup |-> $past(i_power_down))
        else $error("wake outside power down");
    wake_pulse_a: assert property (o_wakeup |=> !o_wakeup)
        else $error("wake not a pulse");
    txd_idle_a: assert property ($rose(i_rstn) |-> o_txd ##1 o_txd)
        else $error("line not idle after reset");
endmodule
bind spc_serial_port spc_chk chk_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce),
    .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
    .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata), .i_power_down(i_power_down),
    .o_txd(o_txd), .o_serial_irq(o_serial_irq), .o_wakeup(o_wakeup));
`default_nettype wire

/* File: sim/spc_remote_node.sv */
// model of the remote asynchronous node on the serial lines
`timescale 1ns/1ps
`default_nettype none
module spc_remote_node #(
    parameter int BIT = 48
) (
    // clock and lines
    input wire logic i_clk,
    input wire logic i_txd,
    input wire logic i_nine,
    output logic o_rxd,
    // captured frames
    output logic [8:0] o_got,
    output logic [7:0] o_got_n
);
    // ****************************************
    // receive side: samples mid bit, lsb first
    // ****************************************
    initial begin
        o_rxd = 1'b1;
        o_got = 9'h000;
        o_got_n = 8'h00;
        forever begin
            @(negedge i_txd);
            repeat (BIT / 2) @(posedge i_clk);
            for (int k = 0; k < (i_nine ? 9 : 8); k++) begin
                repeat (BIT) @(posedge i_clk);
                o_got[k] = i_txd;
            end
            repeat (BIT) @(posedge i_clk);
            o_got_n = o_got_n + 8'h01;
        end
    end
    // send one frame; a zero stop bit makes a framing fault on purpose
    task automatic send(input logic [8:0] d, input logic nine, input logic stop);
        o_rxd <= 1'b0;
        repeat (BIT) @(posedge i_clk);
        for (int k = 0; k < (nine ? 9 : 8); k++) begin
            o_rxd <= d[k];
            repeat (BIT) @(posedge i_clk);
        end
        o_rxd <= stop;
        repeat (BIT) @(posedge i_clk);
        o_rxd <= 1'b1;
        repeat (BIT) @(posedge i_clk);
        #1;
    endtask
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// self-checking bench of the serial port control registers
`timescale 1ns/1ps
`default_nettype none
`include "spc_defines.svh"
module tb;
    // ****************************************
    // signals and instances
    // ****************************************
    logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0, pd = 1'b0;
    logic nine = 1'b0, woke = 1'b0, rxd, txd, irq, wake;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, got_n, v;
    logic [8:0] got;
    int bad_count = 0, n_compared = 0, cyc = 0;
    // reload 0xfd at full speed with doubling gives 48 clocks a bit
    spc_serial_port dut_u (.i_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_sfr_addr(addr),
        .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata),
        .i_timer_reload(8'hfd), .i_power_down(pd), .i_serial_irq_en(1'b1), .i_rxd(rxd),
        .o_txd(txd), .o_rxd_out(), .o_rxd_oe(), .o_serial_irq(irq), .o_wakeup(wake));
    spc_remote_node #(.BIT(48)) node_u (.i_clk(clk), .i_txd(txd), .i_nine(nine),
        .o_rxd(rxd), .o_got(got), .o_got_n(got_n));
    initial begin
        forever #5 clk = ~clk;
    end
    // cycle ceiling well above the roughly eight thousand cycles of all frames
    always @(posedge clk) begin
        cyc++;
        if (wake) woke = 1'b1;
        if (cyc == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // every access starts 1 ns after an edge, so strobes never toggle twice at once
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge clk);
        #1;
        wr = 1'b0;
    endtask
    // read data is registered, so it is taken one cycle after the strobe
    task automatic rd_get(input logic [7:0] a);
        @(posedge clk);
        #1;
        addr = a;
        rd = 1'b1;
        @(posedge clk);
        #1;
        rd = 1'b0;
        v = rdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        rd_get(a);
        chk(9'(v), 9'(e));
    endtask
    task automatic wait_tx();
        v = got_n;
        for (int k = 0; k < 2000 && got_n == v; k++) @(posedge clk);
    endtask
    // one received frame, then a control write clears the done flags
    task automatic rx_case(input logic [7:0] c, input logic [8:0] d, input logic s,
        input logic e);
        wr_reg(`SPC_ADDR_CTRL, c);
        node_u.send(d, c[7], s);
        rd_get(`SPC_ADDR_CTRL);
        chk(9'(v[0]), 9'(e));
        wr_reg(`SPC_ADDR_CTRL, c);
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [7:0] ra [5];
        ra = '{`SPC_ADDR_AUX, `SPC_ADDR_WAKE, `SPC_ADDR_CTRL,
            `SPC_ADDR_MASK, `SPC_ADDR_SADR};
        repeat (3) @(posedge clk);
        #1 rstn = 1'b1;
        rd_chk(`SPC_ADDR_PWR, `SPC_RST_PWR);
        foreach (ra[i]) rd_chk(ra[i], `SPC_RST_ZERO);
        wr_reg(8'h00, 8'hff);
        rd_chk(8'h00, 8'h00);
        ce = 1'b0;
        repeat (3) @(posedge clk);
        #1 ce = 1'b1;
        for (int m = 0; m < 4; m++) begin
            wr_reg(`SPC_ADDR_CTRL, 8'(m << 6));
            rd_chk(`SPC_ADDR_CTRL, 8'(m << 6));
        end
        wr_reg(`SPC_ADDR_AUX, 8'h40);
        wr_reg(`SPC_ADDR_PWR, 8'h80);
        wr_reg(`SPC_ADDR_CTRL, 8'h40);
        wr_reg(`SPC_ADDR_DATA, 8'ha5);
        rd_chk(`SPC_ADDR_DATA, 8'h00);
        wait_tx();
        chk(got, 9'h0a5);
        chk(9'(irq), 9'h001);
        rd_chk(`SPC_ADDR_CTRL, 8'h42);
        rx_case(8'h50, 9'h03c, 1'b1, 1'b1);
        rd_chk(`SPC_ADDR_DATA, 8'h3c);
        rx_case(8'h40, 9'h055, 1'b1, 1'b0);
        rx_case(8'h50, 9'h066, 1'b0, 1'b1);
        wr_reg(`SPC_ADDR_PWR, 8'hc0);
        rd_chk(`SPC_ADDR_CTRL, 8'hd0);
        wr_reg(`SPC_ADDR_CTRL, 8'h50);
        rd_chk(`SPC_ADDR_CTRL, 8'h50);
        wr_reg(`SPC_ADDR_PWR, 8'h80);
        rd_chk(`SPC_ADDR_CTRL, 8'h50);
        nine = 1'b1;
        wr_reg(`SPC_ADDR_CTRL, 8'hc8);
        wr_reg(`SPC_ADDR_DATA, 8'h5a);
        wait_tx();
        chk(got, 9'h15a);
        rx_case(8'hd0, 9'h181, 1'b1, 1'b1);
        chk(9'(v[2]), 9'h001);
        wr_reg(`SPC_ADDR_SADR, 8'h12);
        wr_reg(`SPC_ADDR_MASK, 8'hf0);
        rd_chk(`SPC_ADDR_MASK, 8'hf0);
        rx_case(8'hf0, 9'h11a, 1'b1, 1'b1);
        rx_case(8'hf0, 9'h01a, 1'b1, 1'b0);
        rx_case(8'hf0, 9'h12a, 1'b1, 1'b0);
        rx_case(8'hf0, 9'h1f2, 1'b1, 1'b1);
        rx_case(8'h70, 9'h01a, 1'b1, 1'b1);
        rx_case(8'h70, 9'h01a, 1'b0, 1'b0);
        rx_case(8'h70, 9'h02a, 1'b1, 1'b0);
        wr_reg(`SPC_ADDR_MASK, 8'h00);
        wr_reg(`SPC_ADDR_SADR, 8'h00);
        rx_case(8'hf0, 9'h12a, 1'b1, 1'b1);
        pd = 1'b1;
        wr_reg(`SPC_ADDR_WAKE, 8'h40);
        node_u.send(9'h000, 1'b0, 1'b1);
        pd = 1'b0;
        chk(9'(woke), 9'h001);
        report_and_stop();
    end
endmodule
`default_nettype wire
